// ---- common/adc_ctrl_pkg.sv ----
/*
 Constants, register layout and carrier types for the stereo capture
 control block. Assumes a 32-bit register bus with byte addresses and
 a system clock that also feeds the converter clock divider.
*/
// Notes on behaviour
// [RQ1] stereo 24-bit channels, 128x oversampling
// [RQ2] left enable bit 3, right bit 2
// [RQ3] software mutes gain before clearing enable
// [RQ4] converter clock runs only with clock enable
// [RQ5] converter rate follows sample rate and ratio; the divider here uses the ratio only
// [RQ6] software uses only supported clock ratios
// [RQ7] gain spans -71.625 to +23.625 dB
// [RQ8] gain 0.375*(X-192) dB, zero mutes, reset C0
// [RQ9] separate 8-bit left and right gain fields
// [RQ10] update bit zero only stores held code
// [RQ11] update one loads both gains together
// [RQ12] update bit 8 in both gain registers
// [RQ13] update bit reads back as zero
package adc_ctrl_pkg;
	localparam int SAMPLE_W = 24;
	localparam int OSR = 128;
	localparam int DIV_W = 6;
	localparam int FIFO_DEPTH = 16;
	localparam int ADDR_W = 8;
	// register indices; the byte address is four times the index
	localparam logic [5:0] LEFT_GAIN_IDX = 6'h15;
	localparam logic [5:0] RIGHT_GAIN_IDX = 6'h16;
	localparam logic [5:0] POWER_IDX = 6'h19;
	localparam logic [5:0] CLOCK_CFG_IDX = 6'h08;
	localparam logic [5:0] STATUS_IDX = 6'h09;
	// field positions
	localparam int GAIN_UPDATE_BIT = 8;
	localparam int LEFT_EN_BIT = 3;
	localparam int RIGHT_EN_BIT = 2;
	localparam int CLK_EN_BIT = 0;
	localparam int RATIO_LSB = 4;
	localparam int RATE_LSB = 8;
	localparam int OVERRUN_BIT = 0;
	localparam int LEFT_RUN_BIT = 1;
	localparam int RIGHT_RUN_BIT = 2;
	// reset values and codes
	localparam logic [7:0] GAIN_RESET = 8'hC0;
	localparam logic [7:0] GAIN_MUTE = 8'h00;
	localparam logic [9:0] GAIN_ZERO_DB = 10'h0C0;
	localparam logic [2:0] RATIO_RESET = 3'h0;
	localparam logic [3:0] RATE_RESET = 4'h0;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} sample_pair_t;

	// system clocks per oversampling tick: clock ratio over 128
	function automatic logic [DIV_W-1:0] ratio_divisor(
		input logic [2:0] code);
		logic [DIV_W-1:0] d;
		unique case (code)
			3'h0: d = 6'h02;
			3'h1: d = 6'h03;
			3'h2: d = 6'h04;
			3'h3: d = 6'h06;
			3'h4: d = 6'h08;
			3'h5: d = 6'h0C;
			3'h6: d = 6'h18;
			3'h7: d = 6'h30;
		endcase
		return d;
	endfunction
endpackage

// ---- rtl/sample_fifo.sv ----
/*
 Sample FIFO with valid and ready on both sides.
 Assumes one clock; out_data is only meaningful while out_valid.
*/
module sample_fifo
#(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// honest full and empty straight from the occupancy count
	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr_q];

	// storage, cleared so the output never shows unknowns
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		else if (push)
			mem[wr_ptr_q] <= in_data;
	end

	// pointers and occupancy
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= next_ptr(wr_ptr_q);
			if (pop)
				rd_ptr_q <= next_ptr(rd_ptr_q);
			if (push & ~pop)
				count_q <= count_q + 1'b1;
			else if (pop & ~push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

// ---- rtl/adc_gain_stage.sv ----
/*
 Digital volume for one channel: 0.375 dB steps, code zero mutes.
 Assumes in_valid pulses once per sample; result one cycle later.
*/
module adc_gain_stage
#(
	parameter int W = 24
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// sample in and active gain code
	input wire logic in_valid,
	input wire logic signed [W-1:0] in_sample,
	input wire logic [7:0] gain_code,
	// scaled sample out
	output logic out_valid,
	output logic signed [W-1:0] out_sample
);
	logic signed [9:0] diff;
	logic signed [5:0] octave;
	logic [4:0] shift;
	logic [15:0] mant;
	logic signed [W+16:0] prod;
	logic signed [W+16:0] scaled;
	logic fits;
	logic signed [W-1:0] sat;

	// 2^(r/16) in Q1.15; sixteen steps of 0.375 dB make one 6 dB octave
	function automatic logic [15:0] mantissa(input logic [3:0] r);
		logic [15:0] m;
		unique case (r)
			4'h0: m = 16'h8000;
			4'h1: m = 16'h85AB;
			4'h2: m = 16'h8B96;
			4'h3: m = 16'h91C4;
			4'h4: m = 16'h9838;
			4'h5: m = 16'h9EF5;
			4'h6: m = 16'hA5FF;
			4'h7: m = 16'hAD58;
			4'h8: m = 16'hB505;
			4'h9: m = 16'hBD09;
			4'hA: m = 16'hC567;
			4'hB: m = 16'hCE25;
			4'hC: m = 16'hD745;
			4'hD: m = 16'hE0CD;
			4'hE: m = 16'hEAC1;
			4'hF: m = 16'hF525;
		endcase
		return m;
	endfunction

	// [RQ7] gain law, code minus 192 in steps
	assign diff = $signed({2'b00, gain_code})
		- $signed(adc_ctrl_pkg::GAIN_ZERO_DB);
	assign octave = diff[9:4];
	assign shift = 5'(6'sd15 - octave);
	assign mant = mantissa(diff[3:0]);
	assign prod = in_sample * $signed({1'b0, mant});
	assign scaled = prod >>> shift;
	// clip rather than wrap when boosting near full scale
	assign fits = (&scaled[W+16:W-1]) | ~(|scaled[W+16:W-1]);
	assign sat = fits ? scaled[W-1:0]
		: {scaled[W+16], {(W-1){~scaled[W+16]}}};

	// [RQ8] registered result, code zero mutes
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_valid <= 1'b0;
			out_sample <= '0;
		end
		else
		begin
			out_valid <= in_valid;
			if (in_valid)
				out_sample <= (gain_code == adc_ctrl_pkg::GAIN_MUTE)
					? '0 : sat;
		end
	end

	default clocking gcb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_mute_output: assert property ( // [RQ8]
		in_valid && gain_code == adc_ctrl_pkg::GAIN_MUTE
		|=> out_valid && out_sample == '0)
		else $error("muted code gave nonzero sample");

	a_unity_gain: assert property ( // [RQ7]
		in_valid && gain_code == adc_ctrl_pkg::GAIN_RESET
		|=> out_sample == $past(in_sample))
		else $error("zero dB code altered the sample");
endmodule

// ---- rtl/stereo_adc_enable_volume.sv ----
/*
 Stereo capture control: channel enables, converter clock divider,
 per-channel decimation, staged digital volume and an output FIFO.
 Assumes an Avalon-MM master with byte addresses, one-bit modulator
 streams synchronous to clk, and a sink that may stall the FIFO.
*/
// Chosen here: the Avalon-MM interface to the registers.
module stereo_adc_enable_volume
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// modulator bit streams
	input wire logic left_mod_bit,
	input wire logic right_mod_bit,
	// converter clock tick
	output logic conv_clock_tick,
	// captured sample pairs
	output logic capture_valid,
	input wire logic capture_ready,
	output adc_ctrl_pkg::sample_pair_t capture_data
);
	////////////////////////////////////////////////////////////////////
	// declarations
	logic ack_q;
	logic bus_req;
	logic wr_fire;
	logic [5:0] reg_idx;
	logic [31:0] rd_value;
	logic [31:0] readdata_q;
	logic wr_left;
	logic wr_right;
	logic wr_power;
	logic wr_clock;
	logic wr_status;
	logic gain_update_strobe;
	logic [7:0] left_gain_code_q;
	logic [7:0] right_gain_code_q;
	logic [7:0] left_gain_code_d;
	logic [7:0] right_gain_code_d;
	logic [7:0] left_gain_act_q;
	logic [7:0] right_gain_act_q;
	logic left_conv_enable_q;
	logic right_conv_enable_q;
	logic system_clock_enable_q;
	logic [2:0] ratio_q;
	logic [3:0] rate_q;
	logic overrun_q;
	logic overrun_clr;
	logic [adc_ctrl_pkg::DIV_W-1:0] div_cnt_q;
	logic [adc_ctrl_pkg::DIV_W-1:0] div_last;
	logic conv_tick;
	logic any_en;
	logic [6:0] phase_q;
	logic frame_done;
	logic signed [8:0] left_acc_q;
	logic signed [8:0] right_acc_q;
	logic signed [8:0] left_sum;
	logic signed [8:0] right_sum;
	logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] left_raw;
	logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] right_raw;
	logic left_gain_valid;
	logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] left_scaled;
	logic signed [adc_ctrl_pkg::SAMPLE_W-1:0] right_scaled;
	logic pend_q;
	adc_ctrl_pkg::sample_pair_t pend_data_q;
	logic fifo_in_ready;
	logic lost;
	logic [$bits(adc_ctrl_pkg::sample_pair_t)-1:0] fifo_out;

	// one step of a +-1 integrator over the modulator stream
	function automatic logic signed [8:0] next_acc(
		input logic signed [8:0] acc, input logic b);
		return b ? acc + 9'sh001 : acc - 9'sh001;
	endfunction

	// integrator total to full 24-bit scale; 128 lands at 2^22
	function automatic logic signed [23:0] to_sample(
		input logic signed [8:0] s);
		return {s, 15'h0000};
	endfunction

	////////////////////////////////////////////////////////////////////
	// bus slave: every access answers after exactly one wait cycle
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_q;
	assign wr_fire = avs_write & ack_q;
	assign reg_idx = avs_address[7:2];
	assign avs_readdata = readdata_q;

	// answer phase toggles so back to back requests still wait once
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= bus_req & ~ack_q;
	end

	// read data captured one edge early so it stands when taken
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			readdata_q <= '0;
		else if (avs_read & ~ack_q)
			readdata_q <= rd_value;
	end

	// write decode
	assign wr_left = wr_fire & (reg_idx == adc_ctrl_pkg::LEFT_GAIN_IDX);
	assign wr_right = wr_fire
		& (reg_idx == adc_ctrl_pkg::RIGHT_GAIN_IDX);
	assign wr_power = wr_fire & (reg_idx == adc_ctrl_pkg::POWER_IDX);
	assign wr_clock = wr_fire & (reg_idx == adc_ctrl_pkg::CLOCK_CFG_IDX);
	assign wr_status = wr_fire & (reg_idx == adc_ctrl_pkg::STATUS_IDX);

	// [RQ12] same strobe bit through either gain register
	assign gain_update_strobe = (wr_left | wr_right) & avs_byteenable[1]
		& avs_writedata[adc_ctrl_pkg::GAIN_UPDATE_BIT];

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_value = '0;
		case (reg_idx)
			// [RQ13] strobe bit is not stored, reads zero
			adc_ctrl_pkg::LEFT_GAIN_IDX: rd_value[7:0] = left_gain_code_q;
			adc_ctrl_pkg::RIGHT_GAIN_IDX:
				rd_value[7:0] = right_gain_code_q;
			adc_ctrl_pkg::POWER_IDX:
			begin
				rd_value[adc_ctrl_pkg::LEFT_EN_BIT] = left_conv_enable_q;
				rd_value[adc_ctrl_pkg::RIGHT_EN_BIT] = right_conv_enable_q;
			end
			adc_ctrl_pkg::CLOCK_CFG_IDX:
			begin
				rd_value[adc_ctrl_pkg::CLK_EN_BIT] = system_clock_enable_q;
				rd_value[adc_ctrl_pkg::RATIO_LSB +: 3] = ratio_q;
				rd_value[adc_ctrl_pkg::RATE_LSB +: 4] = rate_q;
			end
			adc_ctrl_pkg::STATUS_IDX:
			begin
				rd_value[adc_ctrl_pkg::OVERRUN_BIT] = overrun_q;
				rd_value[adc_ctrl_pkg::LEFT_RUN_BIT] =
					left_conv_enable_q & system_clock_enable_q;
				rd_value[adc_ctrl_pkg::RIGHT_RUN_BIT] =
					right_conv_enable_q & system_clock_enable_q;
			end
			default: rd_value = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// volume holding and active codes

	// [RQ9] independent held code per channel
	always_comb
	begin
		left_gain_code_d = left_gain_code_q;
		right_gain_code_d = right_gain_code_q;
		if (wr_left & avs_byteenable[0])
			left_gain_code_d = avs_writedata[7:0];
		if (wr_right & avs_byteenable[0])
			right_gain_code_d = avs_writedata[7:0];
	end

	// [RQ8] held codes reset to zero dB
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			left_gain_code_q <= adc_ctrl_pkg::GAIN_RESET;
			right_gain_code_q <= adc_ctrl_pkg::GAIN_RESET;
		end
		else
		begin
			left_gain_code_q <= left_gain_code_d;
			right_gain_code_q <= right_gain_code_d;
		end
	end

	// [RQ10] [RQ11] active gains move together, only on the strobe
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			left_gain_act_q <= adc_ctrl_pkg::GAIN_RESET;
			right_gain_act_q <= adc_ctrl_pkg::GAIN_RESET;
		end
		else if (gain_update_strobe)
		begin
			left_gain_act_q <= left_gain_code_d;
			right_gain_act_q <= right_gain_code_d;
		end
	end

	// [RQ2] channel enables, both off after reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			left_conv_enable_q <= 1'b0;
			right_conv_enable_q <= 1'b0;
		end
		else if (wr_power & avs_byteenable[0])
		begin
			left_conv_enable_q <=
				avs_writedata[adc_ctrl_pkg::LEFT_EN_BIT];
			right_conv_enable_q <=
				avs_writedata[adc_ctrl_pkg::RIGHT_EN_BIT];
		end
	end

	// clock configuration: enable, clock ratio, sample rate
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			system_clock_enable_q <= 1'b0;
			ratio_q <= adc_ctrl_pkg::RATIO_RESET;
			rate_q <= adc_ctrl_pkg::RATE_RESET;
		end
		else if (wr_clock)
		begin
			if (avs_byteenable[0])
			begin
				system_clock_enable_q <=
					avs_writedata[adc_ctrl_pkg::CLK_EN_BIT];
				ratio_q <= avs_writedata[adc_ctrl_pkg::RATIO_LSB +: 3];
			end
			if (avs_byteenable[1])
				rate_q <= avs_writedata[adc_ctrl_pkg::RATE_LSB +: 4];
		end
	end

	////////////////////////////////////////////////////////////////////
	// converter clock

	// [RQ5] divisor picked from the ratio alone; the rate field plays no part
	assign div_last = adc_ctrl_pkg::ratio_divisor(ratio_q) - 6'h01;
	// [RQ4] no tick while the system clock enable is low
	assign conv_tick = system_clock_enable_q & (div_cnt_q >= div_last);
	assign conv_clock_tick = conv_tick;

	// >= guards against a ratio shrinking mid count
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			div_cnt_q <= '0;
		else if (!system_clock_enable_q | conv_tick)
			div_cnt_q <= '0;
		else
			div_cnt_q <= div_cnt_q + 6'h01;
	end

	////////////////////////////////////////////////////////////////////
	// decimation: one sample per channel every 128 ticks
	assign any_en = left_conv_enable_q | right_conv_enable_q;
	// [RQ1] frame closes on the last of 128 oversampling ticks
	assign frame_done = conv_tick & any_en
		& (phase_q == 7'(adc_ctrl_pkg::OSR - 1));
	assign left_sum = next_acc(left_acc_q, left_mod_bit);
	assign right_sum = next_acc(right_acc_q, right_mod_bit);
	// a disabled channel contributes silence, not a stale value
	assign left_raw = left_conv_enable_q ? to_sample(left_sum) : '0;
	assign right_raw = right_conv_enable_q ? to_sample(right_sum) : '0;

	// frame phase, restarts whenever both channels stop
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			phase_q <= '0;
		else if (!any_en | !system_clock_enable_q)
			phase_q <= '0;
		else if (conv_tick)
			phase_q <= phase_q + 7'h01;
	end

	// [RQ2] integrators held at zero while their channel is off
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			left_acc_q <= '0;
			right_acc_q <= '0;
		end
		else
		begin
			if (!left_conv_enable_q | frame_done)
				left_acc_q <= '0;
			else if (conv_tick)
				left_acc_q <= left_sum;
			if (!right_conv_enable_q | frame_done)
				right_acc_q <= '0;
			else if (conv_tick)
				right_acc_q <= right_sum;
		end
	end

	// volume stages share the frame strobe so results pair up
	adc_gain_stage #(.W(adc_ctrl_pkg::SAMPLE_W)) u_left_gain
	(
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(frame_done),
		.in_sample(left_raw),
		.gain_code(left_gain_act_q),
		.out_valid(left_gain_valid),
		.out_sample(left_scaled)
	);

	adc_gain_stage #(.W(adc_ctrl_pkg::SAMPLE_W)) u_right_gain
	(
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(frame_done),
		.in_sample(right_raw),
		.gain_code(right_gain_act_q),
		.out_valid(),
		.out_sample(right_scaled)
	);

	////////////////////////////////////////////////////////////////////
	// staging register into the FIFO; a full FIFO stalls it
	assign lost = left_gain_valid & pend_q & ~fifo_in_ready;
	assign overrun_clr = wr_status & avs_byteenable[0]
		& avs_writedata[adc_ctrl_pkg::OVERRUN_BIT];

	// pending pair waits for FIFO room; a newer pair is then dropped
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pend_q <= 1'b0;
			pend_data_q <= '0;
		end
		else if (left_gain_valid & ~lost)
		begin
			pend_q <= 1'b1;
			pend_data_q <= '{left: left_scaled, right: right_scaled};
		end
		else if (pend_q & fifo_in_ready)
			pend_q <= 1'b0;
	end

	// sticky overrun, a new loss wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			overrun_q <= 1'b0;
		else
			overrun_q <= lost | (overrun_q & ~overrun_clr);
	end

	sample_fifo #(
		.WIDTH($bits(adc_ctrl_pkg::sample_pair_t)),
		.DEPTH(adc_ctrl_pkg::FIFO_DEPTH)
	) u_fifo
	(
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(pend_q),
		.in_ready(fifo_in_ready),
		.in_data(pend_data_q),
		.out_valid(capture_valid),
		.out_ready(capture_ready),
		.out_data(fifo_out)
	);

	assign capture_data = adc_ctrl_pkg::sample_pair_t'(fifo_out);

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_bus_one_wait: assert property (
		bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer took more than one wait cycle");

	a_channel_silence: assert property ( // [RQ2]
		frame_done && !left_conv_enable_q
		|=> left_gain_valid && left_scaled == '0)
		else $error("disabled left channel produced data");

	a_clock_gated: assert property ( // [RQ4]
		!system_clock_enable_q |-> !conv_tick && !frame_done)
		else $error("converter ticked with clock disabled");

	a_tick_period: assert property ( // [RQ5]
		conv_tick ##1 (ratio_q == 3'h3 && system_clock_enable_q) [*6]
		|-> conv_tick && $past(div_cnt_q) == 6'h04)
		else $error("tick spacing does not match the ratio");

	a_frame_close: assert property ( // [RQ1]
		frame_done |=> phase_q == 7'h00 && left_gain_valid)
		else $error("frame did not close after 128 ticks");

	a_hold_only: assert property ( // [RQ10]
		(wr_left || wr_right) && !gain_update_strobe
		|=> $stable(left_gain_act_q) && $stable(right_gain_act_q))
		else $error("gain changed without update strobe");

	a_both_update: assert property ( // [RQ11]
		gain_update_strobe |=> left_gain_act_q == left_gain_code_q
		&& right_gain_act_q == right_gain_code_q)
		else $error("update strobe did not load both gains");

	a_right_strobe: assert property ( // [RQ12]
		wr_right && gain_update_strobe
		|=> left_gain_act_q == left_gain_code_q)
		else $error("right register strobe missed left gain");

	a_separate_codes: assert property ( // [RQ9]
		wr_left && !wr_right |=> $stable(right_gain_code_q))
		else $error("left write disturbed right gain code");

	a_strobe_reads_zero: assert property ( // [RQ13]
		avs_read && !avs_waitrequest
		&& (reg_idx == adc_ctrl_pkg::LEFT_GAIN_IDX
		|| reg_idx == adc_ctrl_pkg::RIGHT_GAIN_IDX)
		|-> avs_readdata[adc_ctrl_pkg::GAIN_UPDATE_BIT] == 1'b0)
		else $error("update bit read back as one");

	a_overrun_sticky: assert property (
		lost |=> overrun_q ##1 (overrun_q || $past(overrun_clr)))
		else $error("overrun flag lost");
endmodule

// ---- dv/capture_sink_model.sv ----
/*
 Far-side model: modulator bit streams and the capture sink.
 Assumes the bench's clk and rst_b; stall holds ready low.
*/
module capture_sink_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bench control
	input wire logic stall,
	// modulator streams
	output logic left_mod_bit,
	output logic right_mod_bit,
	// capture side
	input wire logic capture_valid,
	output logic capture_ready,
	input wire adc_ctrl_pkg::sample_pair_t capture_data,
	output int pops,
	output adc_ctrl_pkg::sample_pair_t last
);
	timeunit 1ns;
	timeprecision 1ns;
	// full scale positive on the left, negative on the right
	assign left_mod_bit = 1'b1;
	assign right_mod_bit = 1'b0;
	////////////////////////////////////////////////////////////
	// ready follows stall one edge late, as a real sink would
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			capture_ready <= 1'b0;
		else
			capture_ready <= !stall;
	end
	// record each pair taken at a valid and ready edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pops <= 0;
			last <= '0;
		end
		else if (capture_valid && capture_ready)
		begin
			pops <= pops + 1;
			last <= capture_data;
		end
	end
endmodule

// ---- dv/stereo_adc_enable_volume_bench.sv ----
/*
 Self-checking bench for the stereo capture control block.
 Assumes the far-side model and a 10 MHz clock; no randomness.
*/
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("BAD %0t got %h want %h", $time, (g), (e)); \
		end \
	end
module stereo_adc_enable_volume_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] LEFT_A = {adc_ctrl_pkg::LEFT_GAIN_IDX, 2'h0};
	localparam logic [7:0] RIGHT_A = {adc_ctrl_pkg::RIGHT_GAIN_IDX, 2'h0};
	localparam logic [7:0] PWR_A = {adc_ctrl_pkg::POWER_IDX, 2'h0};
	localparam logic [7:0] CFG_A = {adc_ctrl_pkg::CLOCK_CFG_IDX, 2'h0};
	localparam logic [7:0] STAT_A = {adc_ctrl_pkg::STATUS_IDX, 2'h0};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h00000000;
	logic [31:0] rdat;
	logic [31:0] v;
	logic wait_r;
	logic tick;
	logic cv;
	logic crdy;
	logic lm;
	logic rm;
	logic stall = 1'b0;
	adc_ctrl_pkg::sample_pair_t cdat;
	adc_ctrl_pkg::sample_pair_t last;
	int pops;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int ticks = 0;

	// 100 ns clock, reset held four cycles
	always #50 clk = ~clk;
	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	end
	// converter ticks counted for rate checks
	always @(posedge clk)
		if (tick === 1'b1)
			ticks++;
	// hang guard: the run needs about 6700 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			give_verdict();
		end
	end

	stereo_adc_enable_volume dut
	(
		.clk(clk),
		.rst_b(rst_b),
		.avs_address(adr),
		.avs_read(rd),
		.avs_write(wr),
		.avs_writedata(wd),
		.avs_byteenable(4'hF),
		.avs_readdata(rdat),
		.avs_waitrequest(wait_r),
		.left_mod_bit(lm),
		.right_mod_bit(rm),
		.conv_clock_tick(tick),
		.capture_valid(cv),
		.capture_ready(crdy),
		.capture_data(cdat)
	);
	capture_sink_model sink
	(
		.clk(clk),
		.rst_b(rst_b),
		.stall(stall),
		.left_mod_bit(lm),
		.right_mod_bit(rm),
		.capture_valid(cv),
		.capture_ready(crdy),
		.capture_data(cdat),
		.pops(pops),
		.last(last)
	);
	////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one access, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		// waitrequest and read data are both taken at the answering edge
		do
			@(posedge clk);
		while (wait_r !== 1'b0);
		v = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// wait for the next popped pair; compare it when asked
	task automatic pair(input logic [23:0] l, input logic [23:0] r,
		input bit chk);
		int p;
		p = pops;
		// only the bench timeout ends this wait
		while (pops == p)
			@(negedge clk);
		if (chk)
		begin
			`CHK(last.left, l)
			`CHK(last.right, r)
		end
	endtask
	// count converter ticks over a window of clocks
	task automatic tick_win(input int len, input int want);
		@(negedge clk);
		ticks = 0;
		repeat (len) @(negedge clk);
		`CHK(ticks, want)
	endtask
	////////////////////////////////////////////////////////////
	task automatic regs_reset();
		bus(0, LEFT_A, 32'h00000000);
		`CHK(v, 32'h000000C0) // left code at reset
		bus(0, RIGHT_A, 32'h00000000);
		`CHK(v, 32'h000000C0) // right code at reset
		bus(0, PWR_A, 32'h00000000);
		`CHK(v[3:2], 2'h0) // enables clear
		bus(1, 8'h3C, 32'hFFFFFFFF);
		bus(0, 8'h3C, 32'h00000000);
		`CHK(v, 32'h00000000)
	endtask
	task automatic rate_gate();
		// ratio 768 gives a tick every 6 clocks
		bus(1, CFG_A, 32'h00000031);
		tick_win(96, 16); // rate from ratio
		bus(1, CFG_A, 32'h00000000);
		tick_win(40, 0); // no tick when gated
		bus(1, CFG_A, 32'h00000001);
	endtask
	task automatic chan_enable();
		bus(1, PWR_A, 32'h00000008);
		bus(0, PWR_A, 32'h00000000);
		`CHK(v, 32'h00000008) // power readback
		pair(24'h000000, 24'h000000, 0);
		pair(24'h400000, 24'h000000, 1); // right idle
		bus(1, PWR_A, 32'h0000000C);
		pair(24'h000000, 24'h000000, 0);
		pair(24'h400000, 24'hC00000, 1); // full-scale pair
	endtask
	task automatic gain_update();
		bus(1, LEFT_A, 32'h000000B0);
		bus(0, LEFT_A, 32'h00000000);
		`CHK(v, 32'h000000B0) // left field held
		pair(24'h400000, 24'hC00000, 1); // active unchanged
		bus(1, RIGHT_A, 32'h000001A0);
		bus(0, RIGHT_A, 32'h00000000);
		`CHK(v, 32'h000000A0) // strobe reads zero
		pair(24'h200000, 24'hF00000, 1); // both load
		bus(1, RIGHT_A, 32'h000000C0);
		bus(1, LEFT_A, 32'h00000100);
		pair(24'h000000, 24'hC00000, 1); // strobe via left
		bus(1, LEFT_A, 32'h000001C0);
	endtask
	task automatic fifo_overrun();
		int p;
		@(posedge clk);
		stall <= 1'b1;
		// eighteen frames of 256 clocks overfill FIFO and staging
		repeat (4672) @(posedge clk);
		bus(0, STAT_A, 32'h00000000);
		`CHK(v[0], 1'b1)
		`CHK(cv, 1'b1)
		bus(1, CFG_A, 32'h00000000);
		p = pops;
		@(posedge clk);
		stall <= 1'b0;
		do
			@(negedge clk);
		while (cv !== 1'b0);
		`CHK(pops - p, 17)
		`CHK(last.left, 24'h400000) // 0 dB sample
		bus(1, STAT_A, 32'h00000001);
		bus(0, STAT_A, 32'h00000000);
		`CHK(v[0], 1'b0)
		bus(1, LEFT_A, 32'h00000000);
		bus(1, RIGHT_A, 32'h00000100);
		bus(1, PWR_A, 32'h00000000);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		wait (rst_b === 1'b1);
		regs_reset();
		rate_gate();
		chan_enable();
		gain_update();
		fifo_overrun();
		give_verdict();
	end
endmodule
